// ===== verilog/vertical_sequence_extensions.v
// Purpose: repetition, hold/restart masking, final length, fifth toggle,
//          alternation and insertion logic of the vertical sequencer
// Assumes: line_start, line_odd and pattern_level come from logic on clock
// Notes: pattern_level is the base toggle logic answer to pattern_phase
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "vertical_seq_regs.vh"
module vertical_sequence_extensions (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [4:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  input  wire        line_start,
  input  wire        line_odd,
  input  wire [3:0]  pattern_level,
  output reg  [12:0] pattern_phase_a,
  output reg  [12:0] pattern_phase_b,
  output reg  [12:0] pattern_phase_c,
  output reg  [12:0] pattern_phase_d,
  output reg  [3:0]  group_out,
  output reg         outputs_held,
  output reg  [1:0]  merged_group
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg  [12:0]              cfg [0:26];
  reg  [`CTRL_WIDTH-1:0]   control;
  reg  [12:0]              pixel_count;
  reg  [1:0]               hold_index;
  reg  [12:0]              pos [0:3];
  reg  [12:0]              rep [0:3];
  reg  [3:0]               run;
  reg  [3:0]               inv;
  reg                      alt_line;
  integer                  i;
  integer                  g;
  integer                  gc;
  integer                  go;
  integer                  ri;

  wire                     alt_en    = control[`CTRL_ALT_BIT];
  wire                     map_en    = control[`CTRL_MAP_BIT];
  wire                     mask_en   = control[`CTRL_MASK_BIT];
  wire [3:0]               final_en  = control[`CTRL_FINAL_LSB +: 4];
  wire [3:0]               fifth_en  = control[`CTRL_FIFTH_LSB +: 4];
  wire [2:0]               insert_en = control[`CTRL_INSERT_LSB +: 3];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [4:0] idx;
    input [4:0] base;
    input [1:0] ofs;
    begin
      idx = base + {3'h0, ofs};
    end
  endfunction

  function [12:0] len_of;
    input [12:0] normal_len;
    input [12:0] final_len;
    input        use_final;
    reg   [12:0] l;
    begin
      l = use_final ? final_len : normal_len;
      len_of = (l == 13'h0000) ? 13'h0001 : l;
    end
  endfunction

  // ----------------------------------------
  // select words and segment control
  // ----------------------------------------
  reg  [17:0] sel0;
  reg  [17:0] sel1;
  reg  [12:0] seg_total;
  reg         mapped;
  reg         mask_on;
  reg  [1:0]  seg_code;
  reg  [1:0]  a_src;

  always @* begin
    mapped = alt_en & map_en;
    mask_on = mask_en & ~mapped; // RL19
    sel0 = 18'h0_0000;
    sel1 = 18'h0_0000;
    if (mapped) begin
      if (line_odd) begin // RL13
        sel0 = {cfg[`IDX_RESTART_POSITION + 5'h02][4:0], cfg[`IDX_HOLD_POSITION + 5'h02]}; // RL4 RL5
        sel1 = {cfg[`IDX_RESTART_POSITION + 5'h03][4:0], cfg[`IDX_HOLD_POSITION + 5'h03]}; // RL4 RL5
      end else begin
        sel0 = {cfg[`IDX_RESTART_POSITION][4:0], cfg[`IDX_HOLD_POSITION]}; // RL4 RL5
        sel1 = {cfg[`IDX_RESTART_POSITION + 5'h01][4:0], cfg[`IDX_HOLD_POSITION + 5'h01]}; // RL4 RL5
      end
    end
    // RL16 RL12
    if (cfg[`IDX_A_FIRST_REPEAT] > `MAX_SEGMENTS)
      seg_total = `MAX_SEGMENTS;
    else
      seg_total = cfg[`IDX_A_FIRST_REPEAT];
    seg_code = 2'h0;
    if (rep[0] < `MAX_SEGMENTS)
      seg_code = {sel0[rep[0][4:0]], sel1[rep[0][4:0]]}; // RL15 RL12
    a_src = 2'h0;
    if (~alt_line && rep[0] == 13'h0000) begin // RL14
      if (insert_en[0])
        a_src = 2'h1;
      else if (insert_en[1])
        a_src = 2'h2;
      else if (insert_en[2])
        a_src = 2'h3;
    end
  end

  // ----------------------------------------
  // repeat counts and lengths per group
  // ----------------------------------------
  reg  [12:0] rep_total [0:3];
  reg  [12:0] cur_len   [0:3];
  reg  [3:0]  last_rep;

  always @* begin
    for (gc = 0; gc < 4; gc = gc + 1) begin
      if (gc == 0)
        rep_total[gc] = alt_line ? seg_total : cfg[`IDX_A_FIRST_REPEAT];
      else if (line_odd) // RL1
        rep_total[gc] = cfg[idx(`IDX_ODD_REPEAT, gc[1:0] - 2'h1)];
      else
        rep_total[gc] = cfg[idx(`IDX_EVEN_REPEAT, gc[1:0] - 2'h1)];
      last_rep[gc] = (rep[gc] == rep_total[gc] - 13'h0001);
      // RL6 RL17
      if (gc == 0 && alt_line)
        cur_len[gc] = len_of(cfg[idx(`IDX_PATTERN_LENGTH, seg_code)], 13'h0000, 1'b0);
      else
        cur_len[gc] = len_of(cfg[idx(`IDX_PATTERN_LENGTH, gc[1:0])],
                             cfg[idx(`IDX_FINAL_LENGTH, gc[1:0])], final_en[gc] & last_rep[gc]);
    end
  end

  // ----------------------------------------
  // pixel counter and hold/restart masking
  // ----------------------------------------
  reg        hold_hit;
  reg  [1:0] hit_index;

  always @* begin
    hold_hit = 1'b0;
    hit_index = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (pixel_count == cfg[idx(`IDX_HOLD_POSITION, i[1:0])]) begin // RL18
        hold_hit = 1'b1;
        hit_index = i[1:0];
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      pixel_count <= 13'h0000;
      outputs_held <= 1'b0;
      hold_index <= 2'h0;
    end else begin
      if (line_start) begin
        pixel_count <= 13'h0000;
        outputs_held <= 1'b0;
      end else begin
        pixel_count <= pixel_count + 13'h0001; // RL18
        if (!mask_on) begin
          outputs_held <= 1'b0;
        end else if (outputs_held) begin
          if (pixel_count == cfg[idx(`IDX_RESTART_POSITION, hold_index)]) // RL3
            outputs_held <= 1'b0;
        end else if (hold_hit) begin // RL2
          outputs_held <= 1'b1;
          hold_index <= hit_index;
        end
      end
    end
  end

  // ----------------------------------------
  // group sequencers
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      for (g = 0; g < 4; g = g + 1) begin
        pos[g] <= 13'h0000;
        rep[g] <= 13'h0000;
      end
      run <= 4'h0;
      inv <= 4'h0;
      alt_line <= 1'b0;
    end else if (line_start) begin
      alt_line <= alt_en; // RL10
      inv <= 4'h0;
      for (g = 0; g < 4; g = g + 1) begin
        pos[g] <= 13'h0000;
        rep[g] <= 13'h0000;
      end
      run[0] <= alt_en ? (seg_total != 13'h0000) : (cfg[`IDX_A_FIRST_REPEAT] != 13'h0000);
      for (g = 1; g < 4; g = g + 1)
        run[g] <= ~alt_en & (rep_total[g] != 13'h0000);
    end else if (!outputs_held) begin
      for (g = 0; g < 4; g = g + 1) begin
        if (run[g]) begin
          // RL8 RL9
          if (fifth_en[g] && last_rep[g] && pos[g] == cfg[idx(`IDX_FIFTH_TOGGLE, g[1:0])])
            inv[g] <= ~inv[g];
          if (pos[g] == cur_len[g] - 13'h0001) begin
            pos[g] <= 13'h0000;
            if (last_rep[g])
              run[g] <= 1'b0;
            else
              rep[g] <= rep[g] + 13'h0001; // RL1 RL12
          end else begin
            pos[g] <= pos[g] + 13'h0001;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // vertical outputs
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      group_out <= 4'h0;
      merged_group <= 2'h0;
      pattern_phase_a <= 13'h0000;
      pattern_phase_b <= 13'h0000;
      pattern_phase_c <= 13'h0000;
      pattern_phase_d <= 13'h0000;
    end else if (!outputs_held) begin // RL2
      pattern_phase_a <= pos[0];
      pattern_phase_b <= alt_line ? pos[0] : pos[1];
      pattern_phase_c <= alt_line ? pos[0] : pos[2];
      pattern_phase_d <= alt_line ? pos[0] : pos[3];
      if (alt_line) begin
        merged_group <= seg_code;
        if (run[0])
          group_out <= {4{pattern_level[seg_code]}}; // RL15
      end else begin
        merged_group <= a_src;
        if (run[0] || inv[0])
          group_out[0] <= pattern_level[a_src] ^ inv[0]; // RL14 RL9
        for (go = 1; go < 4; go = go + 1)
          if (run[go] || inv[go])
            group_out[go] <= pattern_level[go] ^ inv[go]; // RL9
      end
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      for (ri = 0; ri < 27; ri = ri + 1)
        cfg[ri] <= `CFG_RESET;
      control <= `CTRL_RESET;
    end else if (reg_write) begin
      if (reg_addr <= `IDX_LAST_CFG)
        cfg[reg_addr] <= reg_wdata[12:0];
      else if (reg_addr == `IDX_CONTROL)
        control <= reg_wdata[`CTRL_WIDTH-1:0];
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      if (reg_addr <= `IDX_LAST_CFG)
        reg_rdata <= {19'h0_0000, cfg[reg_addr]};
      else if (reg_addr == `IDX_CONTROL)
        reg_rdata <= {18'h0_0000, control};
      else if (reg_addr == `IDX_STATUS)
        reg_rdata <= {11'h000, alt_line, merged_group, run, outputs_held, pixel_count};
      else
        reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // vertical_sequence_extensions

// ===== inc/vertical_seq_regs.vh
// Purpose: register indices, fields and reset values of the vertical sequence extensions
// Assumes: one 32-bit register per index, 5-bit index bus
// Notes: register storage is 13 bits wide unless noted
//
// Function
// RL1 - separate 13-bit repeat counts for groups b, c, d on odd and even lines
// RL2 - with masking on, freeze vertical outputs when pixel count hits a hold position
// RL3 - with masking on, resume outputs when pixel count hits the paired restart position
// RL4 - alternation mode reads hold registers 1-4 as select word low bits
// RL5 - alternation mode reads restart registers 1-4 bits [4:0] as select bits [17:13]
// RL6 - final repetition uses its own length only while its enable bit is set
// RL7 - software programs final length equal to the normal pattern length
// RL8 - optional fifth toggle per group at sequence end, gated by its enable bit
// RL9 - fifth toggle is shared by every output of that group
// RL10 - alternation enable high selects alternation sequencing, else normal
// RL11 - software sets select mapping whenever alternation mode is on
// RL12 - each select bit position is one segment, at most 18 per line
// RL13 - odd lines use odd select pair, even lines use even select pair
// RL14 - insertion enable bits 0/1/2 put group b/c/d into one group a repetition
// RL15 - segment code {sel0,sel1}: 00 a, 01 b, 10 c, 11 d
// RL16 - in alternation mode segment count comes from group a first-line repeat count
// RL17 - final length enable is four bits, group a in the lsb
// RL18 - hold and restart compare against the current line pixel counter
// RL19 - with alternation and mapping on, hold/restart do no masking
`ifndef VERTICAL_SEQ_REGS_VH
`define VERTICAL_SEQ_REGS_VH
`define IDX_PATTERN_LENGTH   5'h00
`define IDX_A_FIRST_REPEAT   5'h04
`define IDX_ODD_REPEAT       5'h05
`define IDX_EVEN_REPEAT      5'h08
`define IDX_HOLD_POSITION    5'h0b
`define IDX_RESTART_POSITION 5'h0f
`define IDX_FINAL_LENGTH     5'h13
`define IDX_FIFTH_TOGGLE     5'h17
`define IDX_LAST_CFG         5'h1a
`define IDX_CONTROL          5'h1b
`define IDX_STATUS           5'h1c
`define CTRL_ALT_BIT         0
`define CTRL_MAP_BIT         1
`define CTRL_MASK_BIT        2
`define CTRL_FINAL_LSB       3
`define CTRL_FIFTH_LSB       7
`define CTRL_INSERT_LSB      11
`define CTRL_WIDTH           14
`define CTRL_RESET           14'h0000
`define CFG_RESET            13'h0000
`define MAX_SEGMENTS         13'h0012
`endif

// ===== dv/base_toggle_model.sv
// Purpose: stand-in for the base toggle logic
// Assumes: level of a group is the lsb of its phase
// Notes: answers combinationally, as the design expects
`timescale 1ns/10ps
module base_toggle_model (
  input  wire [12:0] phase_a,
  input  wire [12:0] phase_b,
  input  wire [12:0] phase_c,
  input  wire [12:0] phase_d,
  output wire [3:0]  level
);
  assign level = {phase_d[0], phase_c[0], phase_b[0], phase_a[0]};
endmodule // base_toggle_model

// ===== dv/vseq_checker.sv
// Purpose: port checks of the vertical sequence extensions
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design top
`timescale 1ns/10ps
module vseq_checker (
  input wire        clock,
  input wire        sys_rst,
  input wire [4:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [31:0] reg_rdata,
  input wire        line_start,
  input wire [12:0] pattern_phase_a,
  input wire [3:0]  group_out,
  input wire        outputs_held
);
  // ----
  // properties
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  reset_zero_a: assert property ($past(sys_rst) |-> group_out == 0 && !outputs_held)
    else $error("outputs not cleared by reset");
  idle_read_a: assert property (!$past(reg_read) |-> reg_rdata == 0)
    else $error("read data outside its cycle");
  field_width_a: assert property ($past(reg_read && reg_addr < 5'h1b) |-> reg_rdata[31:13] == 0)
    else $error("field wider than 13 bits");
  write_read_a: assert property ($past(reg_write, 3) && $past(reg_read) && $past(reg_addr) == $past(reg_addr, 3)
    && $past(reg_addr) < 5'h1b |-> reg_rdata[12:0] == $past(reg_wdata[12:0], 3))
    else $error("read back differs from write");
  unmapped_zero_a: assert property ($past(reg_read && reg_addr > 5'h1c) |-> reg_rdata == 0)
    else $error("unmapped read not zero");
  hold_freeze_a: assert property (outputs_held && $past(outputs_held) && $past(outputs_held, 2)
    |-> $stable(group_out) && $stable(pattern_phase_a))
    else $error("outputs moved while held");
  line_clear_a: assert property (line_start |=> !outputs_held)
    else $error("hold survived line start");
  phase_restart_a: assert property (line_start |-> ##2 pattern_phase_a == 0)
    else $error("phase not restarted");
endmodule // vseq_checker
bind vertical_sequence_extensions vseq_checker vseq_checker_i (.clock(clock), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .line_start(line_start), .pattern_phase_a(pattern_phase_a),
  .group_out(group_out), .outputs_held(outputs_held));

// ===== dv/tb_vertical_sequence_extensions.sv
// Purpose: register and line scenarios of the vertical sequence extensions
// Assumes: index map and control bits of the design
// Notes: base toggle model closes the level loop
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb_vertical_sequence_extensions;
  reg         clock = 0, sys_rst = 1, reg_write = 0, reg_read = 0, line_start = 0, line_odd = 0;
  reg  [4:0]  reg_addr = 0;
  reg  [31:0] reg_wdata = 0;
  wire [31:0] reg_rdata;
  wire [12:0] ph_a, ph_b, ph_c, ph_d;
  wire [3:0]  group_out, level;
  wire        outputs_held;
  wire [1:0]  merged_group;
  reg  [1:0]  q[$];
  reg  [1:0]  ev[4] = '{3, 1, 2, 0};
  reg  [1:0]  od[4] = '{2, 3, 1, 0};
  reg  [12:0] max_a, prev_b;
  reg  [3:0]  go_end;
  reg         h8, h13;
  int         err_total = 0, num_checks = 0, rise_b, i;
  // ----
  // design, model, clock
  // ----
  vertical_sequence_extensions vertical_sequence_extensions_i (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .line_start(line_start), .line_odd(line_odd), .pattern_level(level),
    .pattern_phase_a(ph_a), .pattern_phase_b(ph_b), .pattern_phase_c(ph_c), .pattern_phase_d(ph_d),
    .group_out(group_out), .outputs_held(outputs_held), .merged_group(merged_group));
  base_toggle_model base_toggle_model_i (.phase_a(ph_a), .phase_b(ph_b), .phase_c(ph_c),
    .phase_d(ph_d), .level(level));
  initial forever #5 clock = ~clock;
  task wr(input [4:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clock) reg_write <= 0;
    @(posedge clock);
  endtask
  task rd(input [4:0] a, input [31:0] e);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clock) reg_read <= 0;
    #1 `CHK(reg_rdata, e)
    @(posedge clock);
  endtask
  task do_reset;
    sys_rst <= 1;
    repeat (12) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
  endtask
  task run_line(input odd);
    reg [1:0] last;
    line_odd <= odd;
    line_start <= 1;
    @(posedge clock) line_start <= 0;
    q.delete();
    last = 0;
    max_a = 0;
    rise_b = 0;
    prev_b = 0;
    for (i = 0; i < 24; i++) begin
      @(posedge clock) #1;
      if (merged_group !== last) q.push_back(merged_group);
      last = merged_group;
      if (ph_a > max_a) max_a = ph_a;
      if (ph_b == 1 && prev_b != 1) rise_b++;
      prev_b = ph_b;
      if (i == 6) h8 = outputs_held;
      if (i == 11) h13 = outputs_held;
    end
    go_end = group_out;
    @(posedge clock);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
  // ----
  // scenarios
  // ----
  initial begin
    do_reset;
    for (int k = 0; k < 27; k++) begin
      rd(k[4:0], 0);
      wr(k[4:0], 32'hffff_e000 | (k << 7) | k);
      rd(k[4:0], (k << 7) | k);
    end
    wr(5'h1b, 32'hffff_ffff);
    rd(5'h1b, 32'h0000_3fff);
    wr(5'h1d, 32'hffff_ffff);
    rd(5'h1d, 0);
    do_reset;
    wr(5'h0b, 5);
    wr(5'h0f, 9);
    wr(5'h0c, 32'h0000_0100);
    wr(5'h0d, 32'h0000_0100);
    wr(5'h0e, 32'h0000_0100);
    wr(5'h1b, 4);
    run_line(0);
    `CHK(h8, 1'b1)
    `CHK(h13, 1'b0)
    wr(5'h0c, 3);
    wr(5'h0d, 3);
    wr(5'h0e, 6);
    wr(5'h04, 4);
    wr(5'h1b, 7);
    run_line(0);
    `CHK(h8, 1'b0)
    foreach (ev[j]) `CHK(q[j], ev[j])
    run_line(1);
    foreach (od[j]) `CHK(q[j], od[j])
    `CHK({ph_d, ph_c}, {ph_a, ph_a})
    wr(5'h0b, 0);
    wr(5'h0c, 0);
    wr(5'h0f, 32'h0000_0010);
    wr(5'h10, 32'h0000_0010);
    wr(5'h04, 18);
    run_line(0);
    `CHK(q[0], 2'h3)
    wr(5'h04, 2);
    for (int k = 0; k < 3; k++) begin
      wr(5'h1b, 32'h0000_0800 << k);
      run_line(0);
      `CHK(q[0], k[1:0] + 2'h1)
    end
    wr(5'h00, 1);
    wr(5'h13, 3);
    wr(5'h17, 2);
    wr(5'h1b, 32'h0000_0088);
    run_line(0);
    `CHK(max_a, 13'h0002)
    `CHK(go_end[0], 1'b1)
    wr(5'h1b, 0);
    run_line(0);
    `CHK(max_a, 13'h0000)
    `CHK(go_end[0], 1'b0)
    wr(5'h01, 2);
    wr(5'h14, 2);
    wr(5'h05, 3);
    wr(5'h08, 1);
    wr(5'h1b, 32'h0000_0010);
    run_line(1);
    `CHK(rise_b, 3)
    run_line(0);
    `CHK(rise_b, 1)
    end_of_test;
  end
endmodule // tb_vertical_sequence_extensions
